// file: design/modem_status_pkg.sv
//
// Overview of operation
// - status register at 06h when divisor latch, select, sfr clear
// - halt/resume register when enhanced, select set, sfr clear
// - bit 7 carrier-detect, loopback takes user output two
// - bit 6 ring, loopback takes control bit 2
// - bit 5 data-set-ready, loopback takes control bit 0
// - bit 4 clear-to-send, loopback takes control bit 1
// - bit 3 sets on any carrier change
// - bit 2 sets on ring falling only, i.e. ring_n rising
// - bits 1,0 set on dsr, cts change
// - any change flag with enable raises interrupt
// - count at or below resume level resumes flow
// - count at or above halt level halts flow
// - control bit 4 selects internal loopback
// - control bit 2 selects status or halt/resume
//
package modem_status_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] modem_line_status_ofs = 4'h6;
	localparam logic [7:0] modem_line_status_rst = 8'h00;
	localparam logic [7:0] flow_halt_resume_rst  = 8'h00;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int lfc_divisor_bit  = 7;
	localparam int mcr_loop_bit     = 4;
	localparam int mcr_op2_bit      = 3;
	localparam int mcr_sel_bit      = 2;
	localparam int mcr_rts_bit      = 1;
	localparam int mcr_dtr_bit      = 0;
	localparam int efr_enh_bit      = 4;
	localparam int sfs_sel_bit      = 2;
	localparam logic [6:0] level_unit = 7'h04;
endpackage

// file: design/flow_threshold.sv
`timescale 1ns/10ps
module flow_threshold
	import modem_status_pkg::*;
(
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	// configuration
	input  wire logic [7:0] levels_i,
	input  wire logic [6:0] rx_count_i,
	input  wire logic       auto_rts_i,
	input  wire logic       auto_sw_i,
	// flow outputs
	output logic            rts_n_o,
	output logic            send_xon_o,
	output logic            send_xoff_o
);
	// ----------------------------------------
	// halt state with hysteresis
	// ----------------------------------------
	// between the two levels the last decision holds, so rts does not chatter
	logic       halted;
	logic       next_halted;
	logic [6:0] resume_lvl;
	logic [6:0] halt_lvl;
	logic       at_halt;
	logic       at_resume;

	assign resume_lvl = 7'(levels_i[7:4]) * level_unit;
	assign halt_lvl   = 7'(levels_i[3:0]) * level_unit;
	assign at_halt    = rx_count_i >= halt_lvl;
	assign at_resume  = rx_count_i <= resume_lvl;

	always_comb begin
		next_halted = halted;
		if (at_halt && !halted)
			next_halted = 1'b1;
		else if (at_resume && halted)
			next_halted = 1'b0;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			halted      <= 1'b0;
			rts_n_o     <= 1'b0;
			send_xon_o  <= 1'b0;
			send_xoff_o <= 1'b0;
		end else begin
			halted      <= next_halted;
			rts_n_o     <= auto_rts_i & next_halted;
			send_xoff_o <= auto_sw_i & next_halted & !halted;
			send_xon_o  <= auto_sw_i & !next_halted & halted;
		end
	end
endmodule // flow_threshold

// file: design/modem_status_flow_thresholds.sv
`timescale 1ns/10ps
module modem_status_flow_thresholds
	import modem_status_pkg::*;
(
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	// register port
	input  wire logic [3:0] addr_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	output logic            rvalid_o,
	// selects from neighbouring registers
	input  wire logic [7:0] line_format_control_i,
	input  wire logic [7:0] modem_output_control_i,
	input  wire logic [7:0] enhanced_features_reg_i,
	input  wire logic [7:0] special_function_select_i,
	// modem inputs
	input  wire logic       carrier_detect_n_i,
	input  wire logic       ring_indicator_n_i,
	input  wire logic       dsr_n_i,
	input  wire logic       cts_n_i,
	// interrupt
	input  wire logic       modem_int_en_i,
	output logic            modem_int_o,
	// flow control
	input  wire logic [6:0] rx_count_i,
	input  wire logic       auto_rts_i,
	input  wire logic       auto_sw_i,
	output logic            rts_n_o,
	output logic            send_xon_o,
	output logic            send_xoff_o,
	output logic            loopback_o
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic loop;
	logic sel_msr;
	logic sel_tcr;
	logic at_ofs;

	assign loop    = modem_output_control_i[mcr_loop_bit];
	assign at_ofs  = addr_i == modem_line_status_ofs;
	assign sel_msr = at_ofs && !line_format_control_i[lfc_divisor_bit]
		&& !modem_output_control_i[mcr_sel_bit] && !special_function_select_i[sfs_sel_bit];
	assign sel_tcr = at_ofs && enhanced_features_reg_i[efr_enh_bit]
		&& modem_output_control_i[mcr_sel_bit] && !special_function_select_i[sfs_sel_bit];
	assign loopback_o = loop;

	// ----------------------------------------
	// live status
	// ----------------------------------------
	logic [3:0] live;
	always_comb begin
		if (loop) begin
			live = {modem_output_control_i[mcr_op2_bit],
				modem_output_control_i[mcr_sel_bit],
				modem_output_control_i[mcr_dtr_bit],
				modem_output_control_i[mcr_rts_bit]};
		end else begin
			live = {~carrier_detect_n_i, ~ring_indicator_n_i, ~dsr_n_i, ~cts_n_i};
		end
	end

	// ----------------------------------------
	// change flags
	// ----------------------------------------
	// edges are taken on the status seen by software, so loopback can exercise them
	logic [3:0] prev;
	logic [3:0] delta;
	logic [3:0] next_delta;
	logic [3:0] hit;
	logic       rd_msr;

	assign rd_msr = rd_i && sel_msr;
	// ring flag wants ring_n low to high, i.e. status bit falling
	assign hit = {live[3] ^ prev[3],
		prev[2] & ~live[2],
		live[1] ^ prev[1],
		live[0] ^ prev[0]};

	always_comb begin
		next_delta = delta;
		if (rd_msr)
			next_delta = 4'h0;
		next_delta = next_delta | hit; // set beats clear
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			prev  <= 4'h0;
			delta <= modem_line_status_rst[3:0];
		end else begin
			prev  <= live;
			delta <= next_delta;
		end
	end

	assign modem_int_o = modem_int_en_i && (delta != 4'h0);

	// ----------------------------------------
	// halt/resume register and read port
	// ----------------------------------------
	logic [7:0] levels;
	logic [7:0] next_levels;
	logic [7:0] next_rdata;

	always_comb begin
		next_levels = levels;
		if (wr_i && sel_tcr)
			next_levels = wdata_i;
		next_rdata = 8'h00;
		if (sel_msr)
			next_rdata = {live, delta};
		else if (sel_tcr)
			next_rdata = levels;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			levels   <= flow_halt_resume_rst;
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			levels   <= next_levels;
			rvalid_o <= rd_i && (sel_msr || sel_tcr);
			if (rd_i)
				rdata_o <= next_rdata;
		end
	end

	flow_threshold u_flow (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.levels_i    (levels),
		.rx_count_i  (rx_count_i),
		.auto_rts_i  (auto_rts_i),
		.auto_sw_i   (auto_sw_i),
		.rts_n_o     (rts_n_o),
		.send_xon_o  (send_xon_o),
		.send_xoff_o (send_xoff_o)
	);
endmodule // modem_status_flow_thresholds

// file: verif/modem_peer.sv
`timescale 1ns/10ps
module modem_peer (
	// wanted levels in, handshake lines out, idle high
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] pattern_i,
	output logic      [3:0] lines_n_o
);
	// ---
	// lines
	// ---
	// registered, so lines only move at the rising clock edge or at reset
	always_ff @(posedge mclk_i or posedge rst_i) lines_n_o <= rst_i ? 4'hf : pattern_i;
endmodule // modem_peer

// file: verif/modem_status_properties.sv
`timescale 1ns/10ps
module modem_status_properties (
	input wire logic       mclk_i, rst_i, rd_i, rvalid_o, carrier_detect_n_i, modem_int_en_i, modem_int_o,
	input wire logic       loopback_o, auto_rts_i, auto_sw_i, rts_n_o, send_xon_o, send_xoff_o,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] rdata_o, line_format_control_i, modem_output_control_i, special_function_select_i
);
	// ---
	// checks
	// ---
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence status_rd;
		rd_i && addr_i == 4'h6 && !line_format_control_i[7] && !modem_output_control_i[2]
			&& !special_function_select_i[2];
	endsequence
	AST_ANSWER: assert property (status_rd |=> rvalid_o) else $error("no answer");
	AST_STRAY: assert property (rvalid_o |-> $past(rd_i) && $past(addr_i) == 4'h6) else $error("stray");
	AST_CARRIER: assert property (status_rd ##0 $stable(carrier_detect_n_i) && $stable(modem_output_control_i)
		|=> rdata_o[7] == (modem_output_control_i[4] ? $past(modem_output_control_i[3]) : !$past(carrier_detect_n_i)))
		else $error("carrier bit");
	AST_LOOP: assert property (loopback_o == modem_output_control_i[4]) else $error("loop flag");
	AST_INT: assert property (!modem_int_en_i |-> !modem_int_o) else $error("int while off");
	AST_XOFF: assert property (send_xoff_o |-> $past(auto_sw_i) && !send_xon_o ##1 !send_xoff_o) else $error("xoff");
	AST_XON: assert property (send_xon_o |-> $past(auto_sw_i) ##1 !send_xon_o) else $error("xon");
	AST_RTS: assert property (rts_n_o |-> $past(auto_rts_i)) else $error("rts");
endmodule // modem_status_properties
bind modem_status_flow_thresholds modem_status_properties u_props (.*);

// file: verif/modem_status_flow_thresholds_bench.sv
`timescale 1ns/10ps
module modem_status_flow_thresholds_bench;
	import modem_status_pkg::*;
	// ---
	// signals
	// ---
	logic       mclk_i = 0, rst_i = 1, rd_i = 0, wr_i = 0, modem_int_en_i = 0, auto_rts_i = 0, auto_sw_i = 0;
	logic       rvalid_o, modem_int_o, rts_n_o, send_xon_o, send_xoff_o, loopback_o;
	logic [3:0] addr_i = 4'h6, pat = 4'hf, s = 4'h0, lines_n, n, d;
	logic [6:0] rx_count_i = 7'h00;
	logic [7:0] wdata_i = 8'h00, line_format_control_i = 8'h00, modem_output_control_i = 8'h00, rdata_o, m;
	logic [7:0] enhanced_features_reg_i = 8'h00, special_function_select_i = 8'h00, q[$];
	int         failures = 0, checks_done = 0, i;
	initial forever #20 mclk_i = ~mclk_i;
	modem_peer PEER (.mclk_i, .rst_i, .pattern_i(pat), .lines_n_o(lines_n));
	modem_status_flow_thresholds DUT (.*, .carrier_detect_n_i(lines_n[3]), .ring_indicator_n_i(lines_n[2]),
		.dsr_n_i(lines_n[1]), .cts_n_i(lines_n[0]));
	task check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			failures++;
			$display("MISMATCH %0t saw %h want %h", $time, seen, want);
		end
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task acc(input logic w, input logic [3:0] a, input logic [7:0] v);
		addr_i <= a;
		wdata_i <= v;
		rd_i <= !w;
		wr_i <= w;
		@(posedge mclk_i);
		rd_i <= 1'h0;
		wr_i <= 1'h0;
		@(posedge mclk_i);
	endtask
	// one pattern change per read (several lines may move at once), so flags never pile up in the model
	task status;
		m = modem_output_control_i;
		n = m[4] ? {m[3:2], m[0], m[1]} : ~pat;
		d = (s ^ n) & ~{1'h0, n[2], 2'h0};
		@(negedge mclk_i);
		check(8'(modem_int_o), 8'(modem_int_en_i & |d));
		@(posedge mclk_i);
		q.push_back({n, d});
		s = n;
		acc(0, 4'h6, 8'h00);
	endtask
	task flow(input logic [6:0] c, input logic off, input logic r);
		rx_count_i <= c;
		for (i = 0; i < 9 && (off ? send_xoff_o : send_xon_o) !== 1'h1; i++) @(negedge mclk_i);
		if (i == 9) begin
			failures++;
			$display("MISMATCH %0t flow pulse timed out", $time);
			report_and_stop;
		end
		check(8'(rts_n_o), 8'(r));
		@(posedge mclk_i);
	endtask
	always @(posedge mclk_i) if (rvalid_o === 1'h1) check(rdata_o, q.size() ? q.pop_front() : 8'hxx);
	initial begin
		void'($urandom(84746));
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'h0;
		@(posedge mclk_i);
		status;
		line_format_control_i <= 8'h80;
		acc(0, 4'h6, 8'h00);
		line_format_control_i <= 8'h00;
		acc(0, 4'h5, 8'h00);
		acc(1, 4'h6, 8'hff);
		status;
		$display("decode test done");
		repeat (8) begin
			pat <= 4'($urandom);
			modem_int_en_i <= 1'($urandom);
			repeat (3) @(posedge mclk_i);
			status;
			status;
		end
		$display("status test done");
		repeat (5) begin
			modem_output_control_i <= 8'h10 | 8'($urandom) & 8'h0b;
			repeat (3) @(posedge mclk_i);
			status;
		end
		$display("loopback test done");
		enhanced_features_reg_i <= 8'h10;
		modem_output_control_i <= 8'h04;
		q.push_back(flow_halt_resume_rst);
		acc(0, 4'h6, 8'h00);
		acc(1, 4'h6, 8'h13);
		q.push_back(8'h13);
		acc(0, 4'h6, 8'h00);
		auto_rts_i <= 1'h1;
		auto_sw_i <= 1'h1;
		flow(7'h0c, 1, 1);
		rx_count_i <= 7'h05;
		repeat (4) @(posedge mclk_i);
		check(8'(rts_n_o), 8'h01);
		flow(7'h04, 0, 0);
		$display("flow test done");
		repeat (3) @(posedge mclk_i);
		check(8'(q.size()), 8'h00);
		report_and_stop;
	end
endmodule // modem_status_flow_thresholds_bench
